// File: rtl/ssc_pkg.sv
// Purpose: Constants for the sensor configuration host controller.
// Assumes: 40 MHz system clock, serial clock made by a divider.
// Notes:   Register offsets of the device and of the Wishbone slave.
// How it works
// - Every frame is sixteen bits long
// - First bit one writes, zero reads
// - Seven address bits follow, MSB first
// - Write frames carry eight data bits, MSB first
// - Device samples on rise; clock at most 20 MHz
// - Enable leads half period, trails one period
// - Burst writes keep enable high throughout
// - Read data changes on fall, sampled on rise
// - Read clock kept at 10 MHz or below
// - Wait 1 us after reset before request
// - Hold reset 1 us after supplies stable
// - Upload may start 1 us after release
// - Rewrite recommended settings after each reset
package ssc_pkg;
   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ        = 40000000;          // System clock rate.
   localparam int SCLK_MAX_HZ   = 10000000;          // Serial clock ceiling for reads.
   localparam int SCLK_HALF     = (CLK_HZ + 2*SCLK_MAX_HZ - 1) / (2*SCLK_MAX_HZ);
   localparam int WAIT_NS       = 1000;              // Settling time after reset, in ns.
   localparam int CLK_NS        = 25;                // System clock period in ns.
   localparam int WAIT_CYC      = (WAIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int REQ_CYC       = 4;                 // Frame request pulse width.
   localparam int FRAME_BITS    = 16;                // Bits in one serial frame.
   localparam int ADDR_W        = 7;                 // Device address width.
   localparam int DATA_W        = 8;                 // Device data width.
   // ------------------------------------------------------------------
   // Device register map
   // ------------------------------------------------------------------
   localparam logic [6:0] DEV_FCOUNT_LO = 7'h16;     // Frame count low byte.
   localparam logic [6:0] DEV_FCOUNT_HI = 7'h17;     // Frame count high byte.
   localparam logic [6:0] DEV_TEMP_LO   = 7'h65;     // Temperature low byte.
   localparam logic [6:0] DEV_TEMP_HI   = 7'h66;     // Temperature high byte.
   localparam logic [6:0] DEV_RIGHT_LO  = 7'h67;     // First address on right output.
   localparam logic [6:0] DEV_RIGHT_HI  = 7'h7E;     // Last address on right output.
   // ------------------------------------------------------------------
   // Wishbone register map (byte offsets)
   // ------------------------------------------------------------------
   localparam logic [3:0] WB_CTRL   = 4'h0;          // Reset and frame request.
   localparam logic [3:0] WB_CMD    = 4'h4;          // Serial access command.
   localparam logic [3:0] WB_STATUS = 4'h8;          // Busy, ready, read data.
   localparam int CTRL_RST_BIT  = 0;                 // Hold device in reset.
   localparam int CTRL_REQ_BIT  = 1;                 // Request frames (self clearing).
   localparam int CMD_GO_BIT    = 16;                // Start serial frame.
   localparam int CMD_HOLD_BIT  = 17;                // Keep enable high after frame.
   localparam int ST_BUSY_BIT   = 8;                 // Serial engine busy.
   localparam int ST_READY_BIT  = 9;                 // Settling time elapsed.
   localparam int ST_DONE_BIT   = 10;                // Frame request sent.
   localparam int ST_RIGHT_BIT  = 11;                // Read came from right output.
endpackage

// File: rtl/ssc_sync.sv
// Purpose: Two flip-flop synchroniser for one pin input.
// Assumes: Input is asynchronous to clk_i.
// Notes:   Only the second stage is read by other logic.
`timescale 1ns/1ps
module ssc_sync
(
   // Clock and reset.
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Pin and synchronised level.
   input  wire logic pin_i,
   output logic      sync_o
);
   logic stage1;  // First stage, read only by the second.
   // Sample the pin twice before use.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         stage1 <= 1'b0;
         sync_o <= 1'b0;
      end
      else
      begin
         stage1 <= pin_i;
         sync_o <= stage1;
      end
   end
endmodule // ssc_sync

// File: rtl/ssc_shift.sv
// Purpose: Sixteen bit serial frame engine for the sensor port.
// Assumes: Device samples on rising and launches on falling clock.
// Notes:   Clock is derived from clk_i by a divider.
`timescale 1ns/1ps
module ssc_shift
(
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Command side.
   input  wire logic        go_i,
   input  wire logic        hold_i,
   input  wire logic        wr_i,
   input  wire logic [6:0]  addr_i,
   input  wire logic [7:0]  data_i,
   input  wire logic        miso_i,
   output logic             busy_o,
   output logic [7:0]       rdata_o,
   // Serial pins.
   output logic             sclk_o,
   output logic             en_o,
   output logic             mosi_o
);
   typedef enum logic [3:0]
   {
      SSC_IDLE = 4'h1,
      SSC_LEAD = 4'h2,
      SSC_SHIFT = 4'h4,
      SSC_TAIL = 4'h8
   } ssc_state_e;
   ssc_state_e  state;     // Engine state.
   logic [7:0]  div;       // Half period counter.
   logic [4:0]  bitn;      // Bits already sent.
   logic [15:0] sh;        // Outgoing frame.
   logic [7:0]  rx;        // Incoming data.
   logic        half_end;  // Half period elapsed.
   logic        rd_frame;  // Current frame is a read.
   assign half_end = (div == 8'(ssc_pkg::SCLK_HALF - 1));
   // Frame sequencing: lead half period, 16 bits, one period trail.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state <= SSC_IDLE;
         div <= 8'h00;
         bitn <= 5'h00;
         sh <= 16'h0000;
         rx <= 8'h00;
         rdata_o <= 8'h00;
         sclk_o <= 1'b0;
         en_o <= 1'b0;
         mosi_o <= 1'b0;
         busy_o <= 1'b0;
         rd_frame <= 1'b0;
      end
      else
      begin
         div <= (state == SSC_IDLE || half_end) ? 8'h00 : div + 8'h01;
         unique case (state)
            SSC_IDLE:
            begin
               sclk_o <= 1'b0;
               if (go_i)
               begin
                  // Control bit, address, data, MSB first.
                  sh <= {wr_i, addr_i, data_i};
                  mosi_o <= wr_i;
                  rd_frame <= !wr_i;
                  en_o <= 1'b1;
                  busy_o <= 1'b1;
                  bitn <= 5'h00;
                  state <= SSC_LEAD;
               end
            end
            SSC_LEAD:
               if (half_end)
               begin
                  state <= SSC_SHIFT;  // Enable led by half a period.
               end
            SSC_SHIFT:
               if (half_end)
               begin
                  sclk_o <= !sclk_o;
                  if (!sclk_o)
                  begin
                     // Rising edge: device samples the frame bit.
                     bitn <= bitn + 5'h01;
                  end
                  else
                  begin
                     // Falling edge: next bit out. The read line reaches miso_i
                     // three clocks late, so the level seen now is the one that
                     // stood just before the rise.
                     sh <= {sh[14:0], 1'b0};
                     mosi_o <= sh[14];
                     if (bitn > 5'(ssc_pkg::FRAME_BITS - ssc_pkg::DATA_W))
                     begin
                        rx <= {rx[6:0], miso_i};
                     end
                     if (bitn == 5'(ssc_pkg::FRAME_BITS))
                     begin
                        state <= SSC_TAIL;
                        if (rd_frame)
                        begin
                           rdata_o <= {rx[6:0], miso_i};
                        end
                     end
                  end
               end
            SSC_TAIL:
               if (half_end)
               begin
                  // Clock stays low; two more half periods make the trail.
                  bitn <= bitn + 5'h01;
                  if (bitn == 5'(ssc_pkg::FRAME_BITS + 1))
                  begin
                     // One full period after the last bit.
                     busy_o <= 1'b0;
                     en_o <= hold_i;  // Burst keeps enable high.
                     state <= SSC_IDLE;
                  end
               end
            default:
               state <= SSC_IDLE;
         endcase
      end
   end
endmodule // ssc_shift

// File: rtl/ssc_host.sv
// Purpose: Host controller that configures the sensor over its serial port.
// Assumes: Classic Wishbone slave, 32-bit data, one cycle ack.
// Notes:   Drives reset and frame request pins and enforces settling time.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
module ssc_host
(
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Wishbone slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Sensor pins.
   input  wire logic        out_left_i,
   input  wire logic        out_right_i,
   output logic             sclk_o,
   output logic             en_o,
   output logic             mosi_o,
   output logic             system_reset_low_o,
   output logic             frame_req_o
);
   // ------------------------------------------------------------------
   // Internal signals
   // ------------------------------------------------------------------
   logic        left_s;     // Synchronised left output.
   logic        right_s;    // Synchronised right output.
   logic        miso;       // Selected read line.
   logic        use_right;  // Current read uses right output.
   logic        go;         // Start pulse to the engine.
   logic        hold;       // Keep enable high after frame.
   logic        wr;         // Frame direction.
   logic [6:0]  addr;       // Device address.
   logic [7:0]  wdata;      // Write data.
   logic        busy;       // Engine busy.
   logic [7:0]  rdata;      // Last read data.
   logic        rst_hold;   // Software holds device reset.
   logic [7:0]  wait_cnt;   // Settling counter.
   logic        ready;      // Settling time met.
   logic        req_pend;   // Frame request waiting.
   logic        req_done;   // Frame request sent.
   logic [2:0]  req_cnt;    // Request pulse width counter.
   logic        acc;        // Bus access this cycle.
   logic        req_wr;     // Control write asking for frames.
   logic        sclk_int;   // Engine clock.
   logic        en_int;     // Engine enable.
   logic        mosi_int;   // Engine data.
   assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign req_wr = acc && wb_we_i && wb_adr_i == ssc_pkg::WB_CTRL && wb_sel_i[0]
                   && wb_dat_i[ssc_pkg::CTRL_REQ_BIT];
   // ------------------------------------------------------------------
   // Pin input synchronisers
   // ------------------------------------------------------------------
   ssc_sync u_sync_left
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .pin_i   (out_left_i),
      .sync_o  (left_s)
   );
   ssc_sync u_sync_right
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .pin_i   (out_right_i),
      .sync_o  (right_s)
   );
   // Right output only serves its own range; otherwise use left.
   assign miso = use_right ? right_s : left_s;
   // ------------------------------------------------------------------
   // Serial engine
   // ------------------------------------------------------------------
   ssc_shift u_shift
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .go_i    (go),
      .hold_i  (hold),
      .wr_i    (wr),
      .addr_i  (addr),
      .data_i  (wdata),
      .miso_i  (miso),
      .busy_o  (busy),
      .rdata_o (rdata),
      .sclk_o  (sclk_int),
      .en_o    (en_int),
      .mosi_o  (mosi_int)
   );
   // Register the pins so every output comes from a flip-flop.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         sclk_o <= 1'b0;
         en_o <= 1'b0;
         mosi_o <= 1'b0;
      end
      else
      begin
         sclk_o <= sclk_int;  // 10 MHz keeps read timing safe.
         en_o <= en_int;
         mosi_o <= mosi_int;
      end
   end
   // ------------------------------------------------------------------
   // Command register
   // ------------------------------------------------------------------
   // Full-lane software writes with the go bit start a frame unless the engine is busy or device
   // not yet settled; such writes are dropped.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         go <= 1'b0;
         hold <= 1'b0;
         wr <= 1'b0;
         addr <= 7'h00;
         wdata <= 8'h00;
         use_right <= 1'b0;
      end
      else
      begin
         go <= 1'b0;
         if (acc && wb_we_i && wb_adr_i == ssc_pkg::WB_CMD && wb_sel_i == 4'hF
             && wb_dat_i[ssc_pkg::CMD_GO_BIT] && !busy && !go && ready)
         begin
            go <= 1'b1;
            hold <= wb_dat_i[ssc_pkg::CMD_HOLD_BIT];
            wr <= wb_dat_i[15];
            addr <= wb_dat_i[14:8];
            wdata <= wb_dat_i[7:0];
            use_right <= !wb_dat_i[15]
                         && wb_dat_i[14:8] >= ssc_pkg::DEV_RIGHT_LO
                         && wb_dat_i[14:8] <= ssc_pkg::DEV_RIGHT_HI;
         end
      end
   end
   // ------------------------------------------------------------------
   // Reset pin and settling timer
   // ------------------------------------------------------------------
   // Reset is held while software asks; the timer restarts on release.
   // Software must rewrite its settings after this.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         rst_hold <= 1'b1;
         system_reset_low_o <= 1'b0;
         wait_cnt <= 8'h00;
         ready <= 1'b0;
      end
      else
      begin
         if (acc && wb_we_i && wb_adr_i == ssc_pkg::WB_CTRL && wb_sel_i[0])
         begin
            rst_hold <= wb_dat_i[ssc_pkg::CTRL_RST_BIT];
         end
         system_reset_low_o <= !rst_hold;
         if (!system_reset_low_o)
         begin
            wait_cnt <= 8'h00;
            ready <= 1'b0;
         end
         else if (wait_cnt == 8'(ssc_pkg::WAIT_CYC))
         begin
            ready <= 1'b1;  // 1 us after release.
         end
         else
         begin
            wait_cnt <= wait_cnt + 8'h01;
         end
      end
   end
   // ------------------------------------------------------------------
   // Frame request pulse
   // ------------------------------------------------------------------
   // A request written before settling is dropped; one written later waits
   // for any upload to finish; the device then captures its frame count and starts by mode.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         req_pend <= 1'b0;
         req_done <= 1'b0;
         req_cnt <= 3'h0;
         frame_req_o <= 1'b0;
      end
      else
      begin
         // A new request clears done first, so a pulse ending now still sets it.
         if (req_wr)
         begin
            req_done <= 1'b0;
         end
         if (frame_req_o)
         begin
            if (req_cnt == 3'h0)
            begin
               frame_req_o <= 1'b0;
               req_done <= 1'b1;
            end
            else
            begin
               req_cnt <= req_cnt - 3'h1;
            end
         end
         else if (req_pend && ready && !busy && !go && !en_o)
         begin
            req_pend <= 1'b0;
            frame_req_o <= 1'b1;
            req_cnt <= 3'(ssc_pkg::REQ_CYC - 1);
         end
         // A request written now stays pending behind any running pulse.
         if (req_wr)
         begin
            req_pend <= 1'b1;
         end
         if (!ready)
         begin
            req_pend <= 1'b0;
         end
      end
   end
   // ------------------------------------------------------------------
   // Wishbone answer
   // ------------------------------------------------------------------
   // Ack one cycle after the strobe; unmapped addresses read zero.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= acc;
         wb_dat_o <= 32'h0000_0000;
         if (acc && !wb_we_i)
         begin
            unique case (wb_adr_i)
               ssc_pkg::WB_CTRL:
                  wb_dat_o <= {30'h0, req_pend, rst_hold};
               ssc_pkg::WB_CMD:
                  wb_dat_o <= {14'h0, hold, 1'b0, wr, addr, wdata};
               ssc_pkg::WB_STATUS:
                  wb_dat_o <= {20'h0, use_right, req_done, ready, busy || go, rdata};
               default:
                  wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   sequence s_req_rise;
      $rose(frame_req_o);
   endsequence
   a_req_after_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_req_rise |-> ready && system_reset_low_o)
      else $error("frame request before settling");
   a_req_no_upload: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_req_rise |-> !busy)
      else $error("frame request during upload");
   a_req_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_req_rise |-> frame_req_o [*4] ##1 !frame_req_o)
      else $error("frame request width wrong");
   a_go_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      go |=> busy)
      else $error("engine did not start");
   a_en_lead: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(en_o) |-> !sclk_o [*2])
      else $error("enable lead too short");
   a_en_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      busy && !go |-> en_int)
      else $error("enable dropped in frame");
   a_reset_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !system_reset_low_o |=> !ready)
      else $error("ready during reset");
   a_right_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      use_right |-> !wr && addr >= ssc_pkg::DEV_RIGHT_LO)
      else $error("right output misused");
endmodule // ssc_host

// File: bench/ssc_dev_model.sv
// Purpose: Behavioural sensor serial port on the far side of the host.
// Assumes: The link clock idles low and stands still outside frames.
// Notes:   Host timing faults are counted in viol for the bench to read.
`timescale 1ns/1ps
module ssc_dev_model
#(
   parameter logic [15:0] TEMP_VAL = 16'h1234 // Arbitrary temperature reading.
)
(
   // Device pins.
   input  wire logic system_reset_low_i,
   input  wire logic sclk_i,
   input  wire logic en_i,
   input  wire logic mosi_i,
   input  wire logic frame_req_i,
   output logic      out_left_o,
   output logic      out_right_o
);
   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic [7:0]  regs [128];        // Programming registers.
   logic [15:0] sr;                // Frame bits shifted in so far.
   logic [7:0]  rbuf;              // Byte being returned.
   logic [15:0] captured;          // Frame count taken by a request.
   logic        rd = 1'b0;         // A read frame is returning data.
   logic        right = 1'b0;      // The address is served by the right line.
   logic        first = 1'b0;      // Next rise is the first of an enable.
   int          cnt = 0;           // Bits of the current frame.
   int          en_rises = 0;      // Enable rises seen.
   int          req_n = 0;         // Frame requests seen.
   int          viol = 0;          // Host timing faults.
   realtime     t_en, t_rise, t_rel;
   // Defaults after reset; the frame count is one.
   task automatic load_defaults();
      foreach (regs[i]) regs[i] = 8'h00;
      regs[7'h16] = 8'h01;
   endtask
   initial
   begin
      load_defaults();
      out_left_o = 1'b0;
      out_right_o = 1'b1;
      t_rel = 0.0;
      t_rise = 0.0;
   end
   // ------------------------------------------------------------------
   // Reset and frame request
   // ------------------------------------------------------------------
   always @(negedge system_reset_low_i) load_defaults();
   // Supplies count as stable from time zero.
   always @(posedge system_reset_low_i)
   begin
      if ($realtime < 1000.0) viol++;
      t_rel = $realtime;
   end
   // A request too soon after reset or during an upload is a fault.
   always @(posedge frame_req_i)
   begin
      if ($realtime - t_rel < 1000.0 || en_i) viol++;
      captured = {regs[7'h17], regs[7'h16]};
      req_n++;
   end
   // ------------------------------------------------------------------
   // Serial port
   // ------------------------------------------------------------------
   always @(posedge en_i)
   begin
      t_en = $realtime;
      cnt = 0;
      first = 1'b1;
      en_rises++;
   end
   // Enable must trail the last rise by a period; lines never float.
   always @(negedge en_i)
   begin
      if ($realtime - t_rise < 99.0) viol++;
      out_left_o = ~out_left_o;
      out_right_o = ~out_right_o;
   end
   // Input is sampled on the rise; rises closer than 100 ns are faults.
   always @(posedge sclk_i) if (en_i)
   begin
      if (first ? $realtime - t_en < 49.0 : $realtime - t_rise < 99.0) viol++;
      t_rise = $realtime;
      first = 1'b0;
      sr = {sr[14:0], mosi_i};
      cnt++;
      if (cnt == 8)
      begin
         rd = !sr[7];
         right = sr[6:0] >= 7'h67 && sr[6:0] <= 7'h7E;
         rbuf = sr[6:0] == 7'h65 ? TEMP_VAL[7:0] :
                sr[6:0] == 7'h66 ? TEMP_VAL[15:8] : regs[sr[6:0]];
      end
      if (cnt == 16)
      begin
         if (sr[15] && sr[14:8] != 7'h65 && sr[14:8] != 7'h66) regs[sr[14:8]] = sr[7:0];
         cnt = 0;
         rd = 1'b0;
      end
   end
   // Read data changes on the fall; idle lines keep toggling.
   always @(negedge sclk_i)
   begin
      out_left_o = rd ? rbuf[15-cnt] : ~out_left_o;
      out_right_o = rd && right ? rbuf[15-cnt] : ~out_right_o;
   end
endmodule // ssc_dev_model

// File: bench/ssc_host_tb.sv
// Purpose: Self-checking bench for the sensor configuration host.
// Assumes: The device model answers on the far side of the serial pins.
// Notes:   Registers are reached through classic Wishbone cycles.
`timescale 1ns/1ps
module ssc_host_tb;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic        clk_i = 1'b0;      // System clock.
   logic        rst_n_i = 1'b0;    // Bench reset.
   logic        cyc = 1'b0;        // Wishbone cycle.
   logic        stb = 1'b0;        // Wishbone strobe.
   logic        we = 1'b0;         // Wishbone direction.
   logic [3:0]  adr = 4'h0;        // Wishbone address.
   logic [3:0]  sel = 4'hF;        // Wishbone lanes.
   logic [31:0] wdat = 32'h0;      // Wishbone write data.
   logic [31:0] dat_o, q;          // Read data and last taken word.
   logic        ack, left, right, sclk, en, mosi, rst_low, freq;
   int          miscompares = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          base;
   initial forever #12.5 clk_i = ~clk_i;
   ssc_host dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .out_left_i(left), .out_right_i(right), .sclk_o(sclk), .en_o(en),
      .mosi_o(mosi), .system_reset_low_o(rst_low), .frame_req_o(freq));
   ssc_dev_model mdl (.system_reset_low_i(rst_low), .sclk_i(sclk), .en_i(en),
      .mosi_i(mosi), .frame_req_i(freq), .out_left_o(left), .out_right_o(right));
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   // Prints the verdict and ends the run.
   task automatic conclude();
      if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // A hang counts as a mismatch.
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin miscompares++; conclude(); end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin miscompares++; $display("unexpected %s expected %h seen %h", n, e, s); end
   endtask
   // One classic cycle, held until ack is sampled high.
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r);
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
      do @(posedge clk_i); while (ack !== 1'b1);
      r = dat_o;
      {cyc, stb, we} <= 3'b000;
   endtask
   // Polls status until the engine is idle and settled.
   task automatic wait_idle();
      do wb(1'b0, ssc_pkg::WB_STATUS, 32'h0, 4'hF, q);
      while (q[ssc_pkg::ST_BUSY_BIT] !== 1'b0 || q[ssc_pkg::ST_READY_BIT] !== 1'b1);
   endtask
   task automatic cmd(input logic w, input logic [6:0] a, input logic [7:0] d, input logic h);
      wb(1'b1, ssc_pkg::WB_CMD, {14'h0, h, 1'b1, w, a, d}, 4'hF, q);
      repeat (2) @(posedge clk_i);
      wait_idle();
   endtask
   // Reads a device register and checks data and the line used.
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      cmd(1'b0, a, 8'h00, 1'b0);
      chk("read data", 32'(e), 32'(q[7:0]));
      chk("right line", 32'(a >= 7'h67 && a <= 7'h7E), 32'(q[ssc_pkg::ST_RIGHT_BIT]));
   endtask
   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      wb(1'b0, ssc_pkg::WB_CTRL, 32'h0, 4'hF, q);
      chk("ctrl reset", 32'h1, q);
      chk("device reset pin", 32'h0, 32'(rst_low));
      wb(1'b0, 4'hC, 32'h0, 4'hF, q);
      chk("unmapped", 32'h0, q);
      repeat (40) @(posedge clk_i);
      wb(1'b1, ssc_pkg::WB_CTRL, 32'h0, 4'hF, q);
      wb(1'b1, ssc_pkg::WB_CMD, 32'h00019655, 4'hF, q);
      wait_idle();
      wb(1'b1, ssc_pkg::WB_CMD, 32'h00019655, 4'h3, q);
      repeat (2) @(posedge clk_i);
      wait_idle();
      chk("refused writes", 32'h1, 32'(mdl.regs[7'h16]));
      base = mdl.en_rises;
      cmd(1'b1, 7'h16, 8'h05, 1'b1);
      cmd(1'b1, 7'h17, 8'h00, 1'b0);
      chk("burst enables", 32'(base + 1), 32'(mdl.en_rises));
      chk("count low", 32'h05, 32'(mdl.regs[7'h16]));
      wb(1'b1, ssc_pkg::WB_CMD, 32'h0001983C, 4'hF, q);
      wb(1'b1, ssc_pkg::WB_CMD, 32'h000199C3, 4'hF, q);
      repeat (2) @(posedge clk_i);
      wait_idle();
      chk("first of pair", 32'h3C, 32'(mdl.regs[7'h18]));
      chk("busy refusal", 32'h00, 32'(mdl.regs[7'h19]));
      cmd(1'b1, 7'h70, 8'hA5, 1'b0);
      cmd(1'b1, 7'h7E, 8'h81, 1'b0);
      cmd(1'b1, 7'h65, 8'hFF, 1'b0);
      rd(7'h16, 8'h05);
      rd(7'h65, 8'h34);
      rd(7'h66, 8'h12);
      rd(7'h67, 8'h00);
      rd(7'h70, 8'hA5);
      rd(7'h7E, 8'h81);
      rd(7'h7F, 8'h00);
      wb(1'b1, ssc_pkg::WB_CTRL, 32'h2, 4'hF, q);
      while (mdl.req_n < 1) @(posedge clk_i);
      chk("captured count", 32'h5, 32'(mdl.captured));
      repeat (8) @(posedge clk_i);
      wb(1'b0, ssc_pkg::WB_STATUS, 32'h0, 4'hF, q);
      chk("request done", 32'h1, 32'(q[ssc_pkg::ST_DONE_BIT]));
      wb(1'b1, ssc_pkg::WB_CTRL, 32'h1, 4'hF, q);
      wb(1'b1, ssc_pkg::WB_CTRL, 32'h0, 4'hF, q);
      wait_idle();
      wb(1'b1, ssc_pkg::WB_CTRL, 32'h2, 4'hF, q);
      while (mdl.req_n < 2) @(posedge clk_i);
      chk("default count", 32'h1, 32'(mdl.captured));
      wait_idle();
      rd(7'h70, 8'h00);
      cmd(1'b1, 7'h16, 8'h05, 1'b0);
      chk("rewritten count", 32'h05, 32'(mdl.regs[7'h16]));
      chk("host timing", 32'h0, 32'(mdl.viol));
      conclude();
   end
endmodule // ssc_host_tb
